// ---- rtl/lpd_pkg.sv ----
// Shared constants and types of the LPDDR4 read-burst core
package lpd_pkg;
	// Register byte offsets
	localparam logic [7:0] LPD_CTRL_OFS = 8'h00;
	localparam logic [7:0] LPD_STAT_OFS = 8'h04;
	localparam logic [7:0] LPD_SEED_OFS = 8'h08;
	localparam logic [7:0] LPD_CNT_OFS  = 8'h0C;
	// Field positions
	localparam int LPD_RL_MSB   = 5;
	localparam int LPD_TGL_BIT  = 8;
	localparam int LPD_EXT_BIT  = 9;
	localparam int LPD_OPEN_MSB = 7;
	localparam int LPD_BUSY_BIT = 8;
	localparam int LPD_ERR_BIT  = 16;
	// Reset values
	localparam logic [5:0]  LPD_RL_RST   = 6'h0E;
	localparam logic        LPD_TGL_RST  = 1'b1;
	localparam logic        LPD_EXT_RST  = 1'b0;
	localparam logic [15:0] LPD_SEED_RST = 16'h0000;
	// Smallest latency the line supports
	localparam logic [5:0]  LPD_RL_MIN   = 6'h04;
	// Strobe lengths in link half clocks
	localparam logic [5:0]  LPD_PRE_HALF  = 6'h04;
	localparam logic [5:0]  LPD_POST_STD  = 6'h01;
	localparam logic [5:0]  LPD_POST_EXT  = 6'h03;
	localparam logic [5:0]  LPD_BL16_HALF = 6'h10;
	localparam logic [5:0]  LPD_BL32_HALF = 6'h20;
	// Latency line depth in link clocks
	localparam int LPD_DLY_DEPTH = 64;
	// First-cycle opcodes on the low command lines
	localparam logic [1:0] LPD_OP_ACT = 2'h1;
	localparam logic [1:0] LPD_OP_RD  = 2'h2;
	localparam logic [1:0] LPD_OP_PRE = 2'h3;
	// Burst sequencer states
	typedef enum logic [3:0] {
		LPD_B_IDLE = 4'h1,
		LPD_B_PRE  = 4'h2,
		LPD_B_DATA = 4'h4,
		LPD_B_POST = 4'h8
	} lpd_bst_t;
	// Command decoder states
	typedef enum logic [2:0] {
		LPD_C_IDLE = 3'h1,
		LPD_C_ACT2 = 3'h2,
		LPD_C_CAS2 = 3'h4
	} lpd_cst_t;
endpackage : lpd_pkg

// ---- rtl/lpd_burst_if.sv ----
// Link between the core and its burst sequencer
`timescale 1ns/1ns
interface lpd_burst_if;
	logic        half;     // Link half-clock tick
	logic        start;    // Preamble start request
	logic        bl32;     // 32-beat burst
	logic [7:0]  col;      // Start column
	logic        tgl_pre;  // Toggling preamble
	logic        ext_post; // Extended postamble
	logic [15:0] seed;     // Data pattern seed
	logic        busy;     // Sequencer active
	logic        done;     // Burst finished pulse
	logic        dqs;      // Strobe level
	logic        dqs_oe;   // Strobe driver on
	logic [15:0] dq;       // Data lanes
	logic        dq_oe;    // Data driver on
	modport ctl (output half, start, bl32, col, tgl_pre, ext_post,
		seed, input busy, done, dqs, dqs_oe, dq, dq_oe);
	modport brst (input half, start, bl32, col, tgl_pre, ext_post,
		seed, output busy, done, dqs, dqs_oe, dq, dq_oe);
endinterface : lpd_burst_if

// ---- rtl/lpd_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module lpd_sync #(
	parameter int W = 1
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] s1_q; // Metastable stage
	logic [W-1:0] s2_q; // Second stage
	logic [W-1:0] s3_q; // Third stage

	// Shift chain; change taken once stages two and three agree
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			q    <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end
endmodule : lpd_sync

// ---- rtl/lpd_burst.sv ----
// Read burst sequencer: preamble, data beats, postamble
`timescale 1ns/1ns
module lpd_burst
	import lpd_pkg::*;
(
	input wire logic   clock,
	input wire logic   rst_b,
	lpd_burst_if.brst  b
);
	lpd_bst_t    st_q;     // Sequencer state
	logic [5:0]  cnt_q;    // Halves left in phase
	logic [4:0]  beat_q;   // Beat within burst
	logic [7:0]  col_q;    // Burst start column
	logic        bl32_q;   // Burst length select
	logic        tgl_q;    // Preamble mode
	logic        ext_q;    // Postamble mode
	logic        pend_q;   // Queued gapless burst
	logic        pbl_q;    // Queued length
	logic [7:0]  pcol_q;   // Queued column
	logic        dqs_q;    // Strobe
	logic        dqs_oe_q; // Strobe enable
	logic [15:0] dq_q;     // Data
	logic        dq_oe_q;  // Data enable
	logic        done_q;   // Completion pulse
	logic        go;       // Accept new burst
	logic        nbl;      // Next burst length
	logic [7:0]  ncol;     // Next burst column
	logic        last;     // Final data half

	// Beat pattern: seed mixed with column address
	function automatic logic [15:0] beat_data(
		input logic [7:0] c, input logic [4:0] n);
		beat_data = b.seed ^ {8'h00, c + {3'h0, n}};
	endfunction : beat_data

	// Halves minus one for a burst length
	function automatic logic [5:0] len_m1(input logic l32);
		len_m1 = (l32 ? LPD_BL32_HALF : LPD_BL16_HALF) - 6'h01;
	endfunction : len_m1

	assign go = b.half && b.start &&
		(st_q == LPD_B_IDLE || st_q == LPD_B_POST);
	assign last = (st_q == LPD_B_DATA) && (cnt_q == 6'h00);
	assign nbl  = pend_q ? pbl_q : b.bl32;
	assign ncol = pend_q ? pcol_q : b.col;

	// Burst sequencing and pin levels
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			st_q     <= LPD_B_IDLE;
			cnt_q    <= 6'h00;
			beat_q   <= 5'h00;
			col_q    <= 8'h00;
			bl32_q   <= 1'b0;
			tgl_q    <= 1'b0;
			ext_q    <= 1'b0;
			dqs_q    <= 1'b0;
			dqs_oe_q <= 1'b0;
			dq_q     <= 16'h0000;
			dq_oe_q  <= 1'b0;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (go) begin
				// (RULE16) preamble starts here
				st_q     <= LPD_B_PRE;
				cnt_q    <= LPD_PRE_HALF - 6'h01;
				col_q    <= b.col;
				bl32_q   <= b.bl32;
				tgl_q    <= b.tgl_pre;
				ext_q    <= b.ext_post;
				dqs_oe_q <= 1'b1;
				dqs_q    <= b.tgl_pre;
			end else if (b.half) begin
				unique case (st_q)
					LPD_B_IDLE: begin
						dqs_q <= 1'b0;
					end
					LPD_B_PRE: begin
						if (cnt_q == 6'h00) begin
							// (RULE18) first bit on strobe rise
							st_q    <= LPD_B_DATA;
							cnt_q   <= len_m1(bl32_q);
							beat_q  <= 5'h00;
							dq_q    <= beat_data(col_q, 5'h00);
							dq_oe_q <= 1'b1;
							dqs_q   <= 1'b1;
						end else begin
							// (RULE16) static or toggling
							cnt_q <= cnt_q - 6'h01;
							dqs_q <= tgl_q & ~dqs_q;
						end
					end
					LPD_B_DATA: begin
						if (last) begin
							done_q <= 1'b1;
							if (pend_q || b.start) begin
								// (RULE20) gapless follow-on
								col_q  <= ncol;
								bl32_q <= nbl;
								cnt_q  <= len_m1(nbl);
								beat_q <= 5'h00;
								dq_q   <= beat_data(ncol, 5'h00);
								dqs_q  <= 1'b1;
							end else begin
								// (RULE17) postamble length
								st_q    <= LPD_B_POST;
								cnt_q   <= (ext_q ? LPD_POST_EXT :
									LPD_POST_STD) - 6'h01;
								dq_oe_q <= 1'b0;
								dqs_q   <= 1'b0;
							end
						end else begin
							// (RULE13) successive beats, edge aligned
							cnt_q  <= cnt_q - 6'h01;
							beat_q <= beat_q + 5'h01;
							dq_q   <= beat_data(col_q, beat_q + 5'h01);
							dqs_q  <= ~dqs_q;
						end
					end
					LPD_B_POST: begin
						if (cnt_q == 6'h00) begin
							// (RULE21) release after postamble
							st_q     <= LPD_B_IDLE;
							dqs_oe_q <= 1'b0;
							dqs_q    <= 1'b0;
						end else begin
							cnt_q <= cnt_q - 6'h01;
							dqs_q <= ~dqs_q;
						end
					end
				endcase
			end
		end
	end

	// Queue a read that lands during data
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
			pbl_q  <= 1'b0;
			pcol_q <= 8'h00;
		end else if (b.half && last) begin
			pend_q <= 1'b0;
		end else if (b.half && b.start && st_q == LPD_B_DATA) begin
			// (RULE4) spacing makes the queue one deep
			pend_q <= 1'b1;
			pbl_q  <= b.bl32;
			pcol_q <= b.col;
		end
	end

	assign b.busy   = (st_q != LPD_B_IDLE);
	assign b.done   = done_q;
	assign b.dqs    = dqs_q;
	assign b.dqs_oe = dqs_oe_q;
	assign b.dq     = dq_q;
	assign b.dq_oe  = dq_oe_q;

	// Half counters watched by the checks
	logic [2:0] pre_h_q;
	logic [1:0] post_h_q;
	logic [6:0] dat_h_q;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			pre_h_q  <= 3'h0;
			post_h_q <= 2'h0;
			dat_h_q  <= 7'h00;
		end else if (go) begin
			pre_h_q  <= 3'h1;
		end else if (b.half) begin
			if (st_q == LPD_B_PRE && cnt_q != 6'h00)
				pre_h_q <= pre_h_q + 3'h1;
			if (st_q == LPD_B_PRE && cnt_q == 6'h00)
				dat_h_q <= 7'h01;
			else if (st_q == LPD_B_DATA && !(last && !pend_q &&
				!b.start))
				dat_h_q <= dat_h_q + 7'h01;
			if (last)
				post_h_q <= 2'h1;
			else if (st_q == LPD_B_POST && cnt_q != 6'h00)
				post_h_q <= post_h_q + 2'h1;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	sequence s_data_on;
		$rose(dq_oe_q);
	endsequence

	AST_PRE_LEN: assert property (s_data_on |-> pre_h_q == 3'h4) // RULE16
		else $error("preamble not two clocks");
	AST_PRE_STATIC: assert property ( // RULE16
		st_q == LPD_B_PRE && !tgl_q |-> !dqs_q)
		else $error("static preamble toggled");
	AST_POST_LEN: assert property ($fell(dqs_oe_q) |-> // RULE17
		post_h_q == (ext_q ? 2'h3 : 2'h1))
		else $error("postamble length wrong");
	AST_FIRST_EDGE: assert property (s_data_on |-> $rose(dqs_q)) // RULE18
		else $error("first bit not on strobe rise");
	AST_EDGE_ALIGN: assert property ( // RULE18
		dq_oe_q && $changed(dq_q) |-> $changed(dqs_q))
		else $error("data moved without strobe edge");
	AST_OE_NEST: assert property (dq_oe_q |-> dqs_oe_q) // RULE21
		else $error("data driven outside strobe window");
	AST_BURST_LEN: assert property ($fell(dq_oe_q) |-> // RULE13
		dat_h_q[3:0] == 4'h0 && $past(dq_oe_q, 2))
		else $error("burst cut short");
	AST_GAPLESS: assert property ( // RULE20
		b.half && last && pend_q |=> dq_oe_q ##1 dq_oe_q)
		else $error("gap between seamless bursts");
	AST_COL_ALIGN: assert property ( // RULE14
		s_data_on |-> (dq_q[1:0] ^ b.seed[1:0]) == 2'h0)
		else $error("burst not on four-column boundary");
endmodule : lpd_burst

// ---- rtl/lpd_core.sv ----
// Top of the LPDDR4 core model: pins, decode, banks, registers
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ns
// Function
// (RULE1) Same-bank activates spaced by active plus precharge
// (RULE2) Self refresh exit waits refresh plus margin
// (RULE3) Power-down exit waits larger of minima
// (RULE4) Column commands eight clocks apart, more for BL32
// (RULE5) Read to precharge waits its minimum
// (RULE6) Precharge and activate-to-column need minimum
// (RULE7) All-bank precharge waits before next activate
// (RULE8) Row open time bounded below and above
// (RULE9) Activates to different banks keep spacing
// (RULE10) Explicit precharges four clocks apart
// (RULE11) Four-activate window set by speed grade
// (RULE12) Column commands sampled at edge, bank open
// (RULE13) Bursts run on successive clocks, uninterrupted
// (RULE14) Two low column bits forced zero
// (RULE15) Data follows read latency after command
// (RULE16) Two-clock preamble, static or toggling
// (RULE17) Half or one-and-half clock postamble
// (RULE18) First bit on first post-preamble strobe rise
// (RULE19) Read-to-write turnaround kept by controller
// (RULE20) Reads every spacing interval run gapless
// (RULE21) Drivers only inside impedance windows
// (RULE22) Controller ignores strobe before preamble
// (RULE23) Controller keeps per-bank interval counters
module lpd_core
	import lpd_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [31:0] hrdata,
	input  wire logic        ck_link,
	input  wire logic        cs_link,
	input  wire logic [5:0]  ca_link,
	output logic      [15:0] dq_o,
	output logic             dq_oe,
	output logic             dqs_o,
	output logic             dqs_oe
);
	lpd_burst_if bif ();

	logic        ck_s;      // Synced link clock
	logic        ck_prev_q; // Previous link clock
	logic        rise;      // Link rising edge
	logic        fall;      // Link falling edge
	logic [6:0]  cmd_s;     // Synced select and lines
	logic        cs_s;      // Synced select
	logic [5:0]  ca_s;      // Synced command lines
	lpd_cst_t    cst_q;     // Decoder state
	logic [2:0]  bank_q;    // Addressed bank
	logic        bl_q;      // Burst length of read
	logic [7:0]  open_q;    // Open banks
	logic        act_done;  // Activate completes
	logic        rd_done;   // Read completes
	logic        rd_ok;     // Read to open bank
	logic        pre_cmd;   // Precharge seen
	logic [63:0] dly_v_q;   // Latency line valid
	logic        dly_b_q [LPD_DLY_DEPTH];       // Line length
	logic [5:0]  dly_c_q [LPD_DLY_DEPTH];       // Line column
	logic [5:0]  tap;       // Preamble tap
	logic [5:0]  rl_q;      // Read latency
	logic        tgl_q;     // Toggling preamble
	logic        ext_q;     // Extended postamble
	logic [15:0] seed_q;    // Data seed
	logic [15:0] rcnt_q;    // Finished bursts
	logic        err_q;     // Read to closed bank
	logic        err_clr;   // Software clear
	logic        sel;       // Bus transfer taken
	logic        wr_q;      // Write data phase
	logic [7:0]  addr_q;    // Data phase offset
	logic [31:0] rd_mux;    // Read value

	// Link clock and command lines through synchronisers
	lpd_sync #(.W(1)) u_ck (
		.clock (clock),
		.rst_b (rst_b),
		.d     (ck_link),
		.q     (ck_s)
	);
	lpd_sync #(.W(7)) u_cmd (
		.clock (clock),
		.rst_b (rst_b),
		.d     ({cs_link, ca_link}),
		.q     (cmd_s)
	);
	assign cs_s = cmd_s[6];
	assign ca_s = cmd_s[5:0];

	// Link edge detector
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			ck_prev_q <= 1'b0;
		end else begin
			ck_prev_q <= ck_s;
		end
	end
	assign rise = ck_s & ~ck_prev_q;
	assign fall = ~ck_s & ck_prev_q;

	// Two-cycle command decoder
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cst_q  <= LPD_C_IDLE;
			bank_q <= 3'h0;
			bl_q   <= 1'b0;
		end else if (rise) begin
			unique case (cst_q)
				LPD_C_IDLE: begin
					// (RULE12) sampled at link rise
					if (cs_s && ca_s[1:0] == LPD_OP_ACT) begin
						cst_q  <= LPD_C_ACT2;
						bank_q <= ca_s[4:2];
					end else if (cs_s && ca_s[1:0] == LPD_OP_RD) begin
						cst_q  <= LPD_C_CAS2;
						bank_q <= ca_s[4:2];
						bl_q   <= ca_s[5];
					end
				end
				LPD_C_ACT2: begin
					cst_q <= LPD_C_IDLE;
				end
				LPD_C_CAS2: begin
					cst_q <= LPD_C_IDLE;
				end
			endcase
		end
	end
	assign act_done = rise && cst_q == LPD_C_ACT2;
	assign rd_done  = rise && cst_q == LPD_C_CAS2;
	assign pre_cmd  = rise && cst_q == LPD_C_IDLE && cs_s &&
		ca_s[1:0] == LPD_OP_PRE;
	// (RULE12) only an open bank serves a read
	assign rd_ok    = rd_done && open_q[bank_q];

	// Open-bank tracking
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			open_q <= 8'h00;
		end else if (act_done) begin
			open_q[bank_q] <= 1'b1;
		end else if (pre_cmd && ca_s[5]) begin
			// All-bank precharge
			open_q <= 8'h00;
		end else if (pre_cmd) begin
			open_q[ca_s[4:2]] <= 1'b0;
		end
	end

	// Read latency line, one slot per link clock
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			dly_v_q <= 64'h0000_0000_0000_0000;
		end else if (rise) begin
			// (RULE15) latency counted from final command edge
			dly_v_q <= {dly_v_q[62:0], rd_ok};
		end
	end
	always_ff @(posedge clock) begin
		if (rise) begin
			dly_b_q[0] <= bl_q;
			dly_c_q[0] <= ca_s;
			for (int i = 1; i < LPD_DLY_DEPTH; i++) begin
				dly_b_q[i] <= dly_b_q[i-1];
				dly_c_q[i] <= dly_c_q[i-1];
			end
		end
	end

	// Preamble begins two link clocks before data
	assign tap       = rl_q - 6'h03;
	assign bif.half  = rise | fall;
	assign bif.start = rise & dly_v_q[tap];
	assign bif.bl32  = dly_b_q[tap];
	// (RULE14) low column bits not carried
	assign bif.col   = {dly_c_q[tap], 2'h0};
	assign bif.tgl_pre  = tgl_q;
	assign bif.ext_post = ext_q;
	assign bif.seed     = seed_q;

	lpd_burst u_burst (
		.clock (clock),
		.rst_b (rst_b),
		.b     (bif.brst)
	);

	// Pins straight from sequencer flops
	assign dq_o   = bif.dq;
	assign dq_oe  = bif.dq_oe;
	assign dqs_o  = bif.dqs;
	assign dqs_oe = bif.dqs_oe;

	// Bus address phase accepted
	assign sel = hsel && htrans[1] && hready;

	// Register read multiplexer
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			LPD_CTRL_OFS: begin
				rd_mux[LPD_RL_MSB:0] = rl_q;
				rd_mux[LPD_TGL_BIT]  = tgl_q;
				rd_mux[LPD_EXT_BIT]  = ext_q;
			end
			LPD_STAT_OFS: begin
				rd_mux[LPD_OPEN_MSB:0] = open_q;
				rd_mux[LPD_BUSY_BIT]   = bif.busy;
				rd_mux[LPD_ERR_BIT]    = err_q;
			end
			LPD_SEED_OFS: rd_mux[15:0] = seed_q;
			LPD_CNT_OFS:  rd_mux[15:0] = rcnt_q;
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus slave: zero-wait, always OKAY
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			wr_q      <= 1'b0;
			addr_q    <= 8'h00;
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			wr_q <= sel && hwrite;
			if (sel) begin
				addr_q <= haddr[7:0];
			end
			if (sel && !hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Control and seed registers
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rl_q   <= LPD_RL_RST;
			tgl_q  <= LPD_TGL_RST;
			ext_q  <= LPD_EXT_RST;
			seed_q <= LPD_SEED_RST;
		end else if (wr_q && addr_q == LPD_CTRL_OFS) begin
			// Latency below the line minimum is raised
			rl_q  <= (hwdata[LPD_RL_MSB:0] < LPD_RL_MIN) ?
				LPD_RL_MIN : hwdata[LPD_RL_MSB:0];
			tgl_q <= hwdata[LPD_TGL_BIT];
			ext_q <= hwdata[LPD_EXT_BIT];
		end else if (wr_q && addr_q == LPD_SEED_OFS) begin
			seed_q <= hwdata[15:0];
		end
	end

	// Closed-bank error flag; a new event beats the clear
	assign err_clr = wr_q && addr_q == LPD_STAT_OFS &&
		hwdata[LPD_ERR_BIT];
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			err_q <= 1'b0;
		end else if (rd_done && !open_q[bank_q]) begin
			err_q <= 1'b1;
		end else if (err_clr) begin
			err_q <= 1'b0;
		end
	end

	// Finished burst counter
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rcnt_q <= 16'h0000;
		end else if (bif.done) begin
			rcnt_q <= rcnt_q + 16'h0001;
		end
	end

	// Latency watch for lone reads
	logic [6:0] lat_q;
	logic       solo_q;
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			lat_q  <= 7'h00;
			solo_q <= 1'b0;
		end else if (rd_ok) begin
			lat_q  <= 7'h00;
			solo_q <= ~|dly_v_q & ~bif.busy;
		end else if (rise && lat_q != 7'h7F) begin
			lat_q <= lat_q + 7'h01;
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_RL: assert property ( // RULE15
		rise && dly_v_q[tap] && solo_q |->
		lat_q == {1'b0, rl_q - 6'h03} ##1 bif.dqs_oe)
		else $error("read latency wrong");
	AST_CLOSED_RD: assert property ( // RULE12
		rd_done && !open_q[bank_q] |=> err_q && !dly_v_q[0])
		else $error("read to closed bank accepted");
endmodule : lpd_core

// ---- verification/lpd_host.sv ----
// Controller model driving the link clock and command lines
`timescale 1ns/1ns
module lpd_host
	import lpd_pkg::*;
(
	output logic       ck_link,
	output logic       cs_link,
	output logic [5:0] ca_link
);
	// Clock stands low between frames
	// first command long after start
	initial begin
		ck_link = 1'b0;
		cs_link = 1'b0;
		ca_link = 6'h15;
	end
	task automatic cyc(input logic cs, input logic [5:0] ca);
		cs_link <= cs;
		ca_link <= ca;
		#53 ck_link <= 1'b1;
		#80 ck_link <= 1'b0;
		#27;
	endtask : cyc
	task automatic idle(input int n);
		repeat (n) cyc(1'b0, ~ca_link);
	endtask : idle
	task automatic act(input logic [2:0] ba);
		cyc(1'b1, {1'b0, ba, LPD_OP_ACT});
		cyc(1'b1, 6'h2A);
		idle(4);
	endtask : act
	task automatic pre(input logic [2:0] ba, input logic all);
		cyc(1'b1, {all, ba, LPD_OP_PRE});
		idle(4);
	endtask : pre
	task automatic rd(input logic [2:0] ba, input logic [7:0] c,
		input logic b32);
		cyc(1'b1, {b32, ba, LPD_OP_RD});
		cyc(1'b0, c[7:2]);
	endtask : rd
endmodule : lpd_host

// ---- verification/lpd_core_tb.sv ----
// Self-checking bench of the read-burst core
`timescale 1ns/1ns
module lpd_core_tb;
	import lpd_pkg::*;
	localparam int RLV = 8;   // Latency used in the bursts
	logic        clock, rst_b, hsel, hwrite, hready, dp;
	logic [31:0] haddr, hwdata, hrdata, s;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hreadyout, hresp, ck_link, cs_link, dq_oe, dqs_o, dqs_oe;
	logic [5:0]  ca_link;
	logic [15:0] dq_o, seed;
	logic [2:0]  ba;
	logic        pdq, pds, pso;  // Previous output levels
	int          n_errors, compares, pr, pc, el;
	logic [31:0] q_rd[$], q_dq[$];  // Expected words and beats
	int          q_pre[$], q_post[$], q_t[$];
	assign hready = hreadyout;
	lpd_core u_lpd_core (.clock(clock), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .ck_link(ck_link),
		.cs_link(cs_link), .ca_link(ca_link), .dq_o(dq_o), .dq_oe(dq_oe),
		.dqs_o(dqs_o), .dqs_oe(dqs_oe));
	lpd_host u_lpd_host (.ck_link(ck_link), .cs_link(cs_link),
		.ca_link(ca_link));
	// Free-running system clock
	initial clock = 1'b0;
	always #10 clock = ~clock;
	// Pseudo-random source
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction : xs
	// Compare and count
	task automatic chk(input string nm, input logic [31:0] sn, ex);
		compares++;
		if (sn !== ex) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, ex, sn);
		end
	endtask : chk
	// Counts and verdict
	task stop_test;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : stop_test
	// One AHB-Lite single transfer
	task automatic ahb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hsize <= 3'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
	endtask : ahb
	// Register read with noted result
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		ahb(1'b0, a, ~e);
	endtask : rd
	// Read burst with noted beats, preamble and postamble
	task automatic burst(input logic [2:0] b, input logic [7:0] c,
		input logic b32, input int pre, post);
		for (int i = 0; i < (b32 ? 32 : 16); i++)
			q_dq.push_back({16'h0, seed ^ {8'h00, {c[7:2], 2'b00} + 8'(i)}});
		if (pre >= 0) q_pre.push_back(pre);
		if (pre >= 0) q_t.push_back(int'($time) + 213);
		if (post >= 0) q_post.push_back(post);
		u_lpd_host.rd(b, c, b32);
	endtask : burst
	// Register data phase watcher
	always @(posedge clock) begin
		if (dp) chk("hrdata", hrdata, q_rd.pop_front());
		if (dp) chk("hresp", {31'h0, hresp}, 32'h0);
		dp = rst_b & hsel & htrans[1] & hready & !hwrite;
	end
	// Link output watcher
	always @(posedge clock) begin
		if (dq_oe && (!pdq || dqs_o !== pds))
			chk("dq_o", {16'h0, dq_o}, q_dq.pop_front());
		if (dq_oe) chk("dqs_oe", {31'h0, dqs_oe}, 32'h1);
		if (dqs_oe && !pso) pr = int'(dqs_o);
		else if (!dq_oe && dqs_o && !pds) pr++;
		if (dq_oe && !pdq) begin
			el = (int'($time) - q_t.pop_front()) / 160;
			chk("preamble", pr, q_pre.pop_front());
			chk("latency", el, RLV);
			chk("first_edge", {31'h0, dqs_o}, 32'h1);
		end
		if (pdq && !dq_oe) pc = 0;
		else pc++;
		if (pso && !dqs_oe) chk("postamble", pc, q_post.pop_front());
		pdq = dq_oe;
		pds = dqs_o;
		pso = dqs_oe;
	end
	// Hang guard
	initial begin
		#300000;
		n_errors++;
		stop_test();
	end
	// Main sequence
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{pdq, pds, pso, dp} = '0;
		rst_b = 1'b0;
		s = 32'hEFAB;
		seed = 16'h0000;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		rd(8'h00, 32'h0000010E);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h10, 32'h0);
		ahb(1'b1, 8'h00, 32'h00000102);
		rd(8'h00, 32'h00000104);
		ahb(1'b1, 8'h00, 32'h00000108);
		seed = 16'(xs());
		ahb(1'b1, 8'h08, {16'h0, seed});
		rd(8'h08, {16'h0, seed});
		$display("registers done");
		ba = 3'(xs());
		u_lpd_host.act(ba);
		rd(8'h04, 32'h1 << ba);
		burst(ba, 8'(xs()), 1'b0, 2, 4);
		u_lpd_host.idle(30);
		ahb(1'b1, 8'h00, 32'h00000208);
		burst(ba, 8'hFF, 1'b1, 0, 12);
		u_lpd_host.idle(50);
		$display("single bursts done");
		ahb(1'b1, 8'h00, 32'h00000108);
		u_lpd_host.act(ba ^ 3'h1);
		burst(ba, 8'(xs()), 1'b0, 2, -1);
		u_lpd_host.idle(6);
		burst(ba ^ 3'h1, 8'(xs()), 1'b0, -1, 4);
		u_lpd_host.idle(30);
		$display("gapless reads done");
		u_lpd_host.pre(ba, 1'b0);
		rd(8'h04, 32'h1 << (ba ^ 3'h1));
		u_lpd_host.rd(ba, 8'h40, 1'b0);
		u_lpd_host.idle(30);
		rd(8'h04, 32'h10000 | (32'h1 << (ba ^ 3'h1)));
		ahb(1'b1, 8'h04, 32'h10000);
		rd(8'h04, 32'h1 << (ba ^ 3'h1));
		u_lpd_host.pre(3'h0, 1'b1);
		rd(8'h04, 32'h0);
		rd(8'h0C, 32'h4);
		repeat (4) @(posedge clock);
		chk("beats_left", q_dq.size(), 32'h0);
		chk("left", q_pre.size() + q_post.size() + q_t.size(), 0);
		chk("reads_left", q_rd.size(), 32'h0);
		$display("closed bank done");
		stop_test();
	end
endmodule : lpd_core_tb
